//--- core/gpt_pkg.sv
/*
 * Constants, register map and mode encodings of the dual-module timer block.
 * Assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus.
 */
`default_nettype none
package gpt_pkg;
    // ************************************************
    // Timer indexes: first module 0..2, second 3..4
    // ************************************************
    localparam int NUM_TIMERS = 5;
    localparam int IDX_AUX_A = 0;
    localparam int IDX_CORE = 1;
    localparam int IDX_AUX_B = 2;
    localparam int IDX_SEC_AUX = 3;
    localparam int IDX_SEC_CORE = 4;
    localparam int TIMER_WIDTH = 16;
    // ************************************************
    // Byte offsets on the bus
    // ************************************************
    localparam logic [7:0] OFS_CTRL0 = 8'h00;
    localparam logic [7:0] OFS_CNT0 = 8'h20;
    localparam logic [7:0] OFS_CAPTURE_RELOAD_REGISTER = 8'h40;
    localparam logic [7:0] OFS_FLAGS = 8'h44;
    // ************************************************
    // Control word fields
    // ************************************************
    localparam int CTL_MODE_LSB = 0;
    localparam int CTL_RUN = 2;
    localparam int CTL_DIR_DOWN = 3;
    localparam int CTL_DIR_EXT = 4;
    localparam int CTL_PRE_LSB = 5;
    localparam int CTL_EDGE_RISE = 8;
    localparam int CTL_EDGE_FALL = 9;
    localparam int CTL_GATE_HIGH = 10;
    localparam int CTL_OUT_EN = 11;
    localparam int CTL_CAP_EN = 11;
    localparam int CTL_FUNC_LSB = 12;
    localparam int CTL_LATCH_SRC = 14;
    localparam int CTL_OPTION = 15;
    // ************************************************
    // Flags word fields
    // ************************************************
    localparam int FLG_CAPTURE = 5;
    localparam int FLG_LATCH1 = 6;
    localparam int FLG_LATCH2 = 7;
    // ************************************************
    // Pin vector layout and timing
    // ************************************************
    localparam int NUM_PINS = 11;
    localparam int PIN_DIR0 = 5;
    localparam int PIN_CAPTURE_INPUT_PIN = 10;
    localparam int FIRST_BASE_SHIFT = 2;
    localparam int SECOND_BASE_SHIFT = 1;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    typedef enum logic [1:0] {MODE_TIMER, MODE_GATED, MODE_COUNTER, MODE_QUAD} mode_t;
    typedef enum logic [1:0] {FUNC_COUNT, FUNC_CAPTURE, FUNC_RELOAD, FUNC_SPARE} func_t;
endpackage : gpt_pkg
`default_nettype wire

//--- core/gpt_sync.sv
/*
 * Two flip-flop synchroniser for a vector of pin inputs.
 * Assumes each bit is an independent level from outside the clock domain.
 */
`default_nettype none
module gpt_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_t;

    sync_state_t s;
    sync_state_t next_s;

    // Elaboration-time refusal of an empty vector
    if (WIDTH < 1)
    begin : g_width_check
        $error("gpt_sync: WIDTH must be at least 1");
    end

    always_comb
    begin
        next_s.stage1 = async_in;
        next_s.stage2 = s.stage1;
    end

    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign sync_out = s.stage2;
endmodule : gpt_sync
`default_nettype wire

//--- core/gpt_timer_top.sv
/*
 * Dual-module general purpose timer/counter with an Avalon-MM register slave.
 * Assumes pins are asynchronous, one 100 MHz clock and an asynchronous low reset.
 */
// The register offsets and the Avalon-MM interface to the registers were chosen for this implementation.
// Functional notes
// - Five 16-bit up/down timers: three in module one, two plus capture register.
// - Timers chain only within their own module.
// - Module one timers choose timer, gated, counter or quadrature mode.
// - Timer mode counts prescaled system clock ticks.
// - Counter mode counts selected edges on the timer input pin.
// - Gated mode counts ticks only while the pin is at gate level.
// - Module one finest count period is 4 clock cycles.
// - Direction from a software bit, optionally flipped by a direction pin.
// - Quadrature mode takes count and direction from two phase inputs.
// - Core toggle latch flips on each wrap and can drive a pin.
// - Core toggle latch can clock either auxiliary timer.
// - Auxiliary timer used as capture or reload register does not count.
// - Capture auxiliary latches core value on a selected pin edge.
// - Reload auxiliary loads core on pin edge or latch transition.
// - Two reloads on opposite latch edges yield continuous PWM.
// - Module two finest count period is 2 clock cycles.
// - Module two timers use prescaled clock or external inputs.
// - Second core latch flips on wrap, clocks other timer, drives pin.
// - Second core wraps feed the compare unit and may reload from capture.
// - Capture pin edge latches second aux value, optionally clearing it.
// - Capture may instead trigger on core count or direction pin edges.
`default_nettype none
module gpt_timer_top
    import gpt_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // Avalon-MM slave
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Timer pins
    input wire logic [4:0] timer_gate_count_input_in,
    input wire logic [4:0] timer_direction_input_in,
    input wire logic capture_input_pin_in,
    // Outputs
    output logic core_toggle_output_pin_out,
    output logic second_core_toggle_output_pin_out,
    output logic compare_unit_count_clock_out,
    output logic [5:0] request_flags_out
);
    // ************************************************
    // State
    // ************************************************
    typedef struct packed {
        logic [NUM_TIMERS-1:0][15:0] ctrl;
        logic [NUM_TIMERS-1:0][TIMER_WIDTH-1:0] cnt;
        logic [TIMER_WIDTH-1:0] capreg;
        logic [5:0] flags;
        logic latch1;
        logic latch2;
        logic [15:0] div;
        logic [NUM_PINS-1:0] prev_pins;
        logic waitreq;
        logic [31:0] rdata;
        logic out1;
        logic out2;
        logic ovf_pulse;
    } top_state_t;

    top_state_t s;
    top_state_t next_s;
    logic [NUM_PINS-1:0] pins;

    // ************************************************
    // Helpers
    // ************************************************
    function automatic logic prescale_tick(logic [15:0] div, logic [2:0] pre, int base);
        logic [15:0] mask;
        mask = (16'h0001 << (int'(pre) + base)) - 16'h0001;
        return (div & mask) == mask;
    endfunction : prescale_tick

    // Returns {wrap, value} after one step up or down
    function automatic logic [16:0] step_count(logic [15:0] cnt, logic up);
        if (up)
        begin
            return {cnt == 16'hFFFF, cnt + 16'h0001};
        end
        return {cnt == 16'h0000, cnt - 16'h0001};
    endfunction : step_count

    // Returns {enable, up} for one timer
    function automatic logic [1:0] count_event(logic [15:0] ctl, logic tick, logic in_lvl,
                                                logic in_rise, logic in_fall, logic dir_lvl,
                                                logic dir_rise, logic dir_fall);
        logic up_sw;
        logic edge_hit;
        logic en;
        logic up;
        up_sw = ~ctl[CTL_DIR_DOWN] ^ (ctl[CTL_DIR_EXT] & dir_lvl);
        edge_hit = (ctl[CTL_EDGE_RISE] & in_rise) | (ctl[CTL_EDGE_FALL] & in_fall);
        up = up_sw;
        unique case (mode_t'(ctl[CTL_MODE_LSB +: 2]))
            MODE_TIMER: en = tick;
            MODE_GATED: en = tick & (in_lvl == ctl[CTL_GATE_HIGH]);
            MODE_COUNTER: en = edge_hit;
            MODE_QUAD:
            begin
                // Phase A edge counts up when levels differ, phase B when equal
                en = in_rise | in_fall | dir_rise | dir_fall;
                up = (in_rise | in_fall) ? (in_lvl != dir_lvl) : (in_lvl == dir_lvl);
            end
        endcase
        return {en & ctl[CTL_RUN], up};
    endfunction : count_event

    function automatic logic [15:0] merge_bytes(logic [15:0] old, logic [31:0] wd,
                                                logic [3:0] be);
        return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : merge_bytes

    // ************************************************
    // Pin synchronisers
    // ************************************************
    gpt_sync #(
        .WIDTH(NUM_PINS)
    ) u_sync (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .async_in({capture_input_pin_in, timer_direction_input_in, timer_gate_count_input_in}),
        .sync_out(pins)
    );

    // ************************************************
    // Next state
    // ************************************************
    always_comb
    begin
        logic [NUM_PINS-1:0] rise;
        logic [NUM_PINS-1:0] fall;
        logic [1:0] ev;
        logic [16:0] st;
        logic [5:0] set_flags;
        logic [5:0] clr_flags;
        logic tick1;
        logic tick2;
        logic wrap1;
        logic wrap2;
        logic lrise;
        logic lfall;
        logic trig;
        logic [5:0] word;
        logic access;
        logic [15:0] c;
        next_s = s;
        rise = pins & ~s.prev_pins;
        fall = ~pins & s.prev_pins;
        set_flags = 6'h00;
        clr_flags = 6'h00;
        trig = 1'b0;
        ev = 2'h0;
        st = 17'h00000;
        c = 16'h0000;
        next_s.prev_pins = pins;
        next_s.div = s.div + 16'h0001;
        next_s.ovf_pulse = 1'b0;

        // First module core timer
        c = s.ctrl[IDX_CORE];
        tick1 = prescale_tick(s.div, c[CTL_PRE_LSB +: 3], FIRST_BASE_SHIFT);
        ev = count_event(c, tick1, pins[IDX_CORE], rise[IDX_CORE], fall[IDX_CORE],
                         pins[PIN_DIR0+IDX_CORE], rise[PIN_DIR0+IDX_CORE],
                         fall[PIN_DIR0+IDX_CORE]);
        st = step_count(s.cnt[IDX_CORE], ev[0]);
        wrap1 = ev[1] & st[16];
        if (ev[1])
        begin
            next_s.cnt[IDX_CORE] = st[15:0];
        end
        lrise = wrap1 & ~s.latch1;
        lfall = wrap1 & s.latch1;
        if (wrap1)
        begin
            next_s.latch1 = ~s.latch1;
            set_flags[IDX_CORE] = 1'b1;
        end

        // Auxiliary timers of the first module
        for (int i = 0; i <= IDX_AUX_B; i += 2)
        begin
            c = s.ctrl[i];
            unique case (func_t'(c[CTL_FUNC_LSB +: 2]))
                FUNC_CAPTURE:
                begin
                    // Stopped while capturing
                    if ((c[CTL_EDGE_RISE] & rise[i]) | (c[CTL_EDGE_FALL] & fall[i]))
                    begin
                        next_s.cnt[i] = s.cnt[IDX_CORE];
                        set_flags[i] = 1'b1;
                    end
                end
                FUNC_RELOAD:
                begin
                    if (c[CTL_OPTION])
                    begin
                        trig = (c[CTL_EDGE_RISE] & lrise) | (c[CTL_EDGE_FALL] & lfall);
                    end
                    else
                    begin
                        trig = (c[CTL_EDGE_RISE] & rise[i]) | (c[CTL_EDGE_FALL] & fall[i]);
                    end
                    // Reload beats the count step; the later aux wins a tie
                    if (trig)
                    begin
                        next_s.cnt[IDX_CORE] = s.cnt[i];
                    end
                end
                default:
                begin
                    if (c[CTL_LATCH_SRC])
                    begin
                        ev = {c[CTL_RUN] & wrap1, ~c[CTL_DIR_DOWN]};
                    end
                    else
                    begin
                        ev = count_event(c, tick1, pins[i], rise[i], fall[i], pins[PIN_DIR0+i],
                                         rise[PIN_DIR0+i], fall[PIN_DIR0+i]);
                    end
                    st = step_count(s.cnt[i], ev[0]);
                    if (ev[1])
                    begin
                        next_s.cnt[i] = st[15:0];
                        set_flags[i] = st[16];
                    end
                end
            endcase
        end

        // Second module core timer
        c = s.ctrl[IDX_SEC_CORE];
        tick2 = prescale_tick(s.div, c[CTL_PRE_LSB +: 3], SECOND_BASE_SHIFT);
        ev = count_event(c, tick2, pins[IDX_SEC_CORE], rise[IDX_SEC_CORE], fall[IDX_SEC_CORE],
                         pins[PIN_DIR0+IDX_SEC_CORE], rise[PIN_DIR0+IDX_SEC_CORE],
                         fall[PIN_DIR0+IDX_SEC_CORE]);
        st = step_count(s.cnt[IDX_SEC_CORE], ev[0]);
        wrap2 = ev[1] & st[16];
        if (ev[1])
        begin
            next_s.cnt[IDX_SEC_CORE] = (wrap2 & c[CTL_OPTION]) ? s.capreg : st[15:0];
        end
        if (wrap2)
        begin
            next_s.latch2 = ~s.latch2;
            next_s.ovf_pulse = 1'b1;
            set_flags[IDX_SEC_CORE] = 1'b1;
        end

        // Second module auxiliary timer and capture register
        c = s.ctrl[IDX_SEC_AUX];
        if (c[CTL_LATCH_SRC])
        begin
            ev = {c[CTL_RUN] & wrap2, ~c[CTL_DIR_DOWN]};
        end
        else
        begin
            ev = count_event(c, tick2, pins[IDX_SEC_AUX], rise[IDX_SEC_AUX], fall[IDX_SEC_AUX],
                             pins[PIN_DIR0+IDX_SEC_AUX], rise[PIN_DIR0+IDX_SEC_AUX],
                             fall[PIN_DIR0+IDX_SEC_AUX]);
        end
        st = step_count(s.cnt[IDX_SEC_AUX], ev[0]);
        if (ev[1])
        begin
            next_s.cnt[IDX_SEC_AUX] = st[15:0];
            set_flags[IDX_SEC_AUX] = st[16];
        end
        unique case (c[CTL_FUNC_LSB +: 2])
            2'h0: trig = (c[CTL_EDGE_RISE] & rise[PIN_CAPTURE_INPUT_PIN]) | (c[CTL_EDGE_FALL] & fall[PIN_CAPTURE_INPUT_PIN]);
            2'h1: trig = rise[IDX_CORE] | fall[IDX_CORE];
            2'h2: trig = rise[PIN_DIR0+IDX_CORE] | fall[PIN_DIR0+IDX_CORE];
            2'h3: trig = rise[IDX_CORE] | fall[IDX_CORE] | rise[PIN_DIR0+IDX_CORE]
                         | fall[PIN_DIR0+IDX_CORE];
        endcase
        if (trig & c[CTL_CAP_EN])
        begin
            next_s.capreg = s.cnt[IDX_SEC_AUX];
            set_flags[FLG_CAPTURE] = 1'b1;
            if (c[CTL_OPTION])
            begin
                next_s.cnt[IDX_SEC_AUX] = CNT_RESET;
            end
        end

        // ************************************************
        // Bus slave: one wait cycle, then the access takes effect
        // ************************************************
        word = avs_address_in[7:2];
        access = avs_read_in | avs_write_in;
        next_s.waitreq = 1'b1;
        if (access & s.waitreq)
        begin
            next_s.waitreq = 1'b0;
        end
        // Read data only moves on a read, so it holds across writes
        if (avs_read_in & s.waitreq)
        begin
            next_s.rdata = 32'h0000_0000;
            if (word < 6'(NUM_TIMERS))
            begin
                next_s.rdata = {16'h0000, s.ctrl[word[2:0]]};
            end
            else if (word >= OFS_CNT0[7:2] && word < OFS_CNT0[7:2] + 6'(NUM_TIMERS))
            begin
                next_s.rdata = {16'h0000, s.cnt[3'(word - OFS_CNT0[7:2])]};
            end
            else if (word == OFS_CAPTURE_RELOAD_REGISTER[7:2])
            begin
                next_s.rdata = {16'h0000, s.capreg};
            end
            else if (word == OFS_FLAGS[7:2])
            begin
                next_s.rdata = {24'h000000, s.latch2, s.latch1, s.flags};
            end
        end
        else if (avs_write_in & ~s.waitreq)
        begin
            if (word < 6'(NUM_TIMERS))
            begin
                next_s.ctrl[word[2:0]] = merge_bytes(s.ctrl[word[2:0]], avs_writedata_in,
                                                     avs_byteenable_in);
            end
            else if (word >= OFS_CNT0[7:2] && word < OFS_CNT0[7:2] + 6'(NUM_TIMERS))
            begin
                next_s.cnt[3'(word - OFS_CNT0[7:2])] = merge_bytes(
                    s.cnt[3'(word - OFS_CNT0[7:2])], avs_writedata_in, avs_byteenable_in);
            end
            else if (word == OFS_CAPTURE_RELOAD_REGISTER[7:2])
            begin
                next_s.capreg = merge_bytes(s.capreg, avs_writedata_in, avs_byteenable_in);
            end
            else if (word == OFS_FLAGS[7:2] && avs_byteenable_in[0])
            begin
                clr_flags = avs_writedata_in[5:0];
            end
        end
        // A flag raised in the clearing cycle survives
        next_s.flags = (s.flags & ~clr_flags) | set_flags;
        next_s.out1 = next_s.latch1 & s.ctrl[IDX_CORE][CTL_OUT_EN];
        next_s.out2 = next_s.latch2 & s.ctrl[IDX_SEC_CORE][CTL_OUT_EN];
    end

    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            s <= '0;
            s.waitreq <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    assign avs_readdata_out = s.rdata;
    assign avs_waitrequest_out = s.waitreq;
    assign core_toggle_output_pin_out = s.out1;
    assign second_core_toggle_output_pin_out = s.out2;
    assign compare_unit_count_clock_out = s.ovf_pulse;
    assign request_flags_out = s.flags;
endmodule : gpt_timer_top
`default_nettype wire

//--- dv/gpt_timer_top_monitor.sv
/* Concurrent checks on the timer block's bus and event ports.
   Assumes it is bound to gpt_timer_top and sees only its ports. */
`default_nettype none
module gpt_timer_top_monitor
    import gpt_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // Bus
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    // Events
    input wire logic compare_unit_count_clock_out,
    input wire logic [5:0] request_flags_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    // ********
    // Bus timing
    // ********
    answer_next_a: assert property (
        (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("bus answer not one cycle after request");
    answer_single_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low longer than one cycle");
    idle_wait_a: assert property (!(avs_read_in || avs_write_in) |=> avs_waitrequest_out)
        else $error("answer without request");
    upper_zero_a: assert property (!avs_waitrequest_out |-> avs_readdata_out[31:16] == 16'h0000)
        else $error("upper read data not zero");
    unmapped_zero_a: assert property (
        avs_read_in && avs_waitrequest_out && avs_address_in >= 8'h48 |=> avs_readdata_out == 0)
        else $error("unmapped read not zero");
    data_hold_a: assert property ($changed(avs_readdata_out) |-> $past(avs_read_in))
        else $error("read data moved without a read");
    // ********
    // Events
    // ********
    flag_sticky_a: assert property (
        |($past(request_flags_out) & ~request_flags_out)
        |-> $past(avs_write_in) && $past(avs_address_in) == OFS_FLAGS)
        else $error("flag cleared without flags write");
    cmp_pulse_a: assert property ($rose(compare_unit_count_clock_out) |=>
        !compare_unit_count_clock_out) else $error("compare clock pulse too long");
    cmp_flag_a: assert property (compare_unit_count_clock_out |-> ##[0:2]
        request_flags_out[4]) else $error("second core wrap without flag");
endmodule : gpt_timer_top_monitor
`default_nettype wire

//--- dv/gpt_pins_model.sv
/* Pin-side model: gate/count, direction and capture pin levels.
   Assumes the bench calls its tasks right after a rising edge. */
`default_nettype none
module gpt_pins_model (
    // Clock
    input wire logic clock_in,
    // Pin levels
    output logic [4:0] gate_out,
    output logic [4:0] dir_out,
    output logic cap_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        gate_out = 5'h00;
        dir_out = 5'h00;
        cap_out = 1'b0;
    end
    // Each level stands 6 cycles so the synchroniser cannot miss an edge
    task automatic hold(input int i, input logic v);
        if (i == 5)
            cap_out <= v;
        else
            gate_out[i] <= v;
        repeat (6) @(posedge clock_in);
    endtask : hold
    task automatic set_dir(input int i, input logic v);
        dir_out[i] <= v;
        repeat (6) @(posedge clock_in);
    endtask : set_dir
    task automatic pulses(input int i, input int n);
        repeat (n)
        begin
            hold(i, 1'b1);
            hold(i, 1'b0);
        end
    endtask : pulses
    // Gray steps on phase A (gate 1) and phase B (direction 1)
    task automatic quad(input int n, input logic fwd);
        repeat (n)
        begin
            if ((gate_out[1] == dir_out[1]) == fwd)
                hold(1, ~gate_out[1]);
            else
                set_dir(1, ~dir_out[1]);
        end
    endtask : quad
endmodule : gpt_pins_model
`default_nettype wire

//--- dv/gpt_timer_top_tb.sv
/* Self-checking bench of the dual-module timer block.
   Assumes the pin model and the bound monitor of dv/. */
`default_nettype none
module gpt_timer_top_tb import gpt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [7:0] avs_address_in = 8'h00;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0000_0000;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    wire logic [4:0] gate;
    wire logic [4:0] dir;
    wire logic cap;
    logic core_pin, sec_pin;
    logic [5:0] flags;
    int failures = 0;
    int checks = 0;
    logic [31:0] q;
    always #5 clock_in = ~clock_in;
    gpt_timer_top u_dut (.clock_in(clock_in), .rstn_in(rstn_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(4'hF), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .timer_gate_count_input_in(gate),
        .timer_direction_input_in(dir), .capture_input_pin_in(cap),
        .core_toggle_output_pin_out(core_pin), .second_core_toggle_output_pin_out(sec_pin),
        .compare_unit_count_clock_out(), .request_flags_out(flags));
    gpt_pins_model u_pins (.clock_in(clock_in), .gate_out(gate), .dir_out(dir), .cap_out(cap));
    // ********
    // Tasks
    // ********
    task automatic print_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // Request held until waitrequest is sampled low; released at that edge, task returns one edge later
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= w;
        avs_read_in <= !w;
        do
        begin
            @(posedge clock_in);
            n++;
        end
        while (avs_waitrequest_out !== 1'b0 && n < 20);
        q = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        if (n >= 20)
        begin
            failures++;
            print_verdict();
        end
        @(posedge clock_in);
    endtask : bus
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), q, exp);
    endtask : rc
    // ********
    // Sequence
    // ********
    initial
    begin
        repeat (20) @(posedge clock_in);
        rstn_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        rc(8'h04, 32'h0);
        rc(8'h24, 32'h0);
        bus(1'b1, 8'h20, 32'hABCD_FFFF);
        rc(8'h20, 32'h0000_FFFF);
        rc(8'h48, 32'h0);
        bus(1'b1, 8'h20, 32'h0);
        bus(1'b1, 8'h04, 32'h4);
        bus(1'b1, 8'h0C, 32'h4);
        repeat (394) @(posedge clock_in);
        bus(1'b1, 8'h04, 32'h0);
        bus(1'b1, 8'h0C, 32'h0);
        bus(1'b0, 8'h24, 32'h0);
        chk("first rate", q >= 32'h62 && q <= 32'h66, 32'h1);
        bus(1'b0, 8'h2C, 32'h0);
        chk("second rate", q >= 32'hC6 && q <= 32'hCA, 32'h1);
        bus(1'b1, 8'h00, 32'h106);
        u_pins.pulses(0, 5);
        rc(8'h20, 32'h5);
        u_pins.set_dir(0, 1'b1);
        bus(1'b1, 8'h00, 32'h116);
        u_pins.pulses(0, 3);
        rc(8'h20, 32'h2);
        bus(1'b1, 8'h08, 32'h405);
        repeat (100) @(posedge clock_in);
        rc(8'h28, 32'h0);
        u_pins.hold(2, 1'b1);
        repeat (94) @(posedge clock_in);
        u_pins.hold(2, 1'b0);
        bus(1'b1, 8'h08, 32'h0);
        bus(1'b0, 8'h28, 32'h0);
        chk("gated", q >= 32'h16 && q <= 32'h1C, 32'h1);
        bus(1'b1, 8'h24, 32'h0);
        bus(1'b1, 8'h04, 32'h307);
        u_pins.quad(4, 1'b1);
        rc(8'h24, 32'h4);
        u_pins.quad(2, 1'b0);
        rc(8'h24, 32'h2);
        bus(1'b1, 8'h04, 32'h0);
        u_pins.hold(1, 1'b0);
        u_pins.set_dir(1, 1'b0);
        bus(1'b1, 8'h24, 32'h0);
        bus(1'b1, 8'h04, 32'h90E);
        u_pins.pulses(1, 1);
        rc(8'h24, 32'hFFFF);
        chk("core pin", core_pin, 32'h1);
        bus(1'b0, OFS_FLAGS, 32'h0);
        chk("wrap flags", q & 32'h42, 32'h42);
        bus(1'b1, OFS_FLAGS, 32'h2);
        bus(1'b0, OFS_FLAGS, 32'h0);
        chk("flag clear", q & 32'h42, 32'h40);
        bus(1'b1, 8'h04, 32'h0);
        bus(1'b1, 8'h24, 32'h1234);
        bus(1'b1, 8'h00, 32'h1104);
        u_pins.pulses(0, 1);
        repeat (40) @(posedge clock_in);
        rc(8'h20, 32'h1234);
        bus(1'b1, 8'h28, 32'h5555);
        bus(1'b1, 8'h08, 32'h2100);
        u_pins.pulses(2, 1);
        rc(8'h24, 32'h5555);
        bus(1'b1, 8'h2C, 32'h0ABC);
        bus(1'b1, 8'h0C, 32'h8900);
        u_pins.pulses(5, 1);
        rc(OFS_CAPTURE_RELOAD_REGISTER, 32'h0ABC);
        rc(8'h2C, 32'h0);
        chk("capture flag", flags[5], 32'h1);
        bus(1'b1, 8'h2C, 32'h0DEF);
        bus(1'b1, 8'h0C, 32'h1900);
        u_pins.pulses(1, 1);
        rc(OFS_CAPTURE_RELOAD_REGISTER, 32'h0DEF);
        bus(1'b1, 8'h30, 32'hFFFF);
        bus(1'b1, 8'h10, 32'h804);
        repeat (10) @(posedge clock_in);
        chk("second pin", sec_pin, 32'h1);
        bus(1'b0, OFS_FLAGS, 32'h0);
        chk("second wrap", q & 32'h90, 32'h90);
        bus(1'b1, 8'h10, 32'h0);
        print_verdict();
    end
endmodule : gpt_timer_top_tb
bind gpt_timer_top gpt_timer_top_monitor u_mon (.clock_in(clock_in), .rstn_in(rstn_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .compare_unit_count_clock_out(compare_unit_count_clock_out),
    .request_flags_out(request_flags_out));
`default_nettype wire
